/* File: rtl/poes_pkg.sv */
// Constants and carrier types for the pin output-enable selector.
// How it works
// - Timer1 pin A drives on valid field.
// - Timer0 pin D drives unless buffer B.
// - Timer0 pin C drives unless buffer A.
// - Timer0 pin B drives on valid field.
// - Timer0 pin A drives on valid field.
// - Smart-card serial clock output enable conditions.
// - Normal serial clock output enable conditions.
// - Bus clock needs direction, running, select.
// - Sync master drives data out when transmitting, except bidirectional with receive on.
// - Sync slave drives data out bidirectional only.
// - Clock-synchronous mode drives data out on transmit.
// - Data-in pin drives in slave unidirectional transmit.
// - Sync clock pin drives when master internal.
// - Chip-select drives on code 10 or master 11.
// - Otherwise direction bit picks output or input.
`default_nettype none
package poes_pkg;
	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register offsets.
	localparam logic [7:0] OFS_TMR0_HI = 8'h00;
	localparam logic [7:0] OFS_TMR0_LO = 8'h04;
	localparam logic [7:0] OFS_TMR_MODE = 8'h08;
	localparam logic [7:0] OFS_TMR1 = 8'h0c;
	localparam logic [7:0] OFS_SER4 = 8'h10;
	localparam logic [7:0] OFS_CLK = 8'h14;
	localparam logic [7:0] OFS_SYNC0 = 8'h18;
	localparam logic [7:0] OFS_SYNC_STEP = 8'h04;
	localparam logic [7:0] OFS_DIR = 8'h24;
	localparam logic [7:0] OFS_OE = 8'h28;
	localparam logic [7:0] OFS_PERIPH = 8'h2c;
	// Timer field positions.
	localparam int TIO_LO_LSB = 0;
	localparam int TIO_HI_LSB = 4;
	localparam int TIO_W = 4;
	localparam int TMODE_BUFA_BIT = 0;
	localparam int TMODE_BUFB_BIT = 1;
	// Serial channel 4 field positions.
	localparam int SER_CKE_LSB = 0;
	localparam int SER_TE_BIT = 2;
	localparam int SER_RE_BIT = 3;
	localparam int SER_SYNC_BIT = 4;
	localparam int SER_GM_BIT = 5;
	localparam int SER_SMART_CARD_SELECT_BIT = 6;
	// Clock control field positions.
	localparam int CLK_STOP_BIT = 0;
	localparam int CLK_POSEL_BIT = 1;
	// Sync serial unit field positions.
	localparam int SYN_TE_BIT = 0;
	localparam int SYN_RE_BIT = 1;
	localparam int SYN_MSS_BIT = 2;
	localparam int SYN_BIDIRECTIONAL_SELECT_BIT = 3;
	localparam int SYN_SERIAL_CLOCK_SELECT_BIT = 4;
	localparam int SYN_CS_LSB = 5;
	localparam int SYN_MODE_BIT = 7;
	// Pin indices.
	localparam int PIN_T1A = 0;
	localparam int PIN_T0D = 1;
	localparam int PIN_T0C = 2;
	localparam int PIN_T0B = 3;
	localparam int PIN_T0A = 4;
	localparam int PIN_SERIAL4_CLOCK_PIN = 5;
	localparam int PIN_BCLK = 6;
	localparam int PIN_SYNC_BASE = 7;
	localparam int PINS_PER_SYNC = 4;
	localparam int SYNC_SO = 0;
	localparam int SYNC_SI = 1;
	localparam int SYNC_SCK = 2;
	localparam int SYNC_CS = 3;
	localparam int SYNC_UNITS = 3;
	// Field codes.
	localparam logic [1:0] TIO_OFF = 2'h0;
	localparam logic [1:0] CKE_OUT = 2'h1;
	localparam logic [1:0] CS_ALWAYS = 2'h2;
	localparam logic [1:0] CS_MASTER = 2'h3;
	// Configuration carriers.
	typedef struct packed {
		logic       bufB;
		logic       bufA;
		logic [3:0] pin_d_io_field;
		logic [3:0] pin_c_io_field;
		logic [3:0] pin_b_io_field;
		logic [3:0] pin_a_io_field;
		logic [3:0] t1ioA;
	} poes_tmr_type;
	typedef struct packed {
		logic       smart_card_select;
		logic       gm;
		logic       syncMode;
		logic       re;
		logic       te;
		logic [1:0] cke;
	} poes_ser_type;
	typedef struct packed {
		logic posel;
		logic stop;
	} poes_clk_type;
	typedef struct packed {
		logic       mode;
		logic [1:0] cs;
		logic       serial_clock_select;
		logic       bidirectional_select;
		logic       master_slave_select;
		logic       re;
		logic       te;
	} poes_sync_type;
	// Reset values.
	localparam poes_tmr_type TMR_RST = '0;
	localparam poes_ser_type SER_RST = '0;
	localparam poes_clk_type CLK_RST = '0;
	localparam poes_sync_type SYNC_RST = '0;
	// A timer pin field selects an output when bit 3 is clear and bits 1:0 are nonzero.
	function automatic logic poes_tio_drives(input logic [3:0] f);
		return !f[3] && (f[1:0] != TIO_OFF);
	endfunction
endpackage
`default_nettype wire

/* File: rtl/poes_pin_mux.sv */
// Output-enable selector for shared port pins with its register port.
`default_nettype none
module poes_pin_mux
	import poes_pkg::*;
#(
	parameter int NUM_SYNC = SYNC_UNITS,
	localparam int NPINS = PIN_SYNC_BASE + PINS_PER_SYNC * NUM_SYNC
) (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              nrst,
	// Register port.
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [DATA_W-1:0] regRdata,
	// Pin control.
	output logic      [NPINS-1:0]  pinOe,
	output logic      [NPINS-1:0]  pinPeriph
);

	// Configuration registers.
	poes_tmr_type              tmrCfg_reg;
	poes_ser_type              serCfg_reg;
	poes_clk_type              clkCfg_reg;
	poes_sync_type             syncCfg_reg [NUM_SYNC];
	logic         [NPINS-1:0]  dir_reg;
	logic         [NPINS-1:0]  periphOe;
	logic         [DATA_W-1:0] rdata_next;

	// Byte address of one sync unit register.
	function automatic logic [ADDR_W-1:0] sync_ofs(input int u);
		return OFS_SYNC0 + OFS_SYNC_STEP * ADDR_W'(u);
	endfunction

	// Unpacks a written word into a sync unit configuration.
	function automatic poes_sync_type to_sync(input logic [DATA_W-1:0] d);
		poes_sync_type s;
		s.te = d[SYN_TE_BIT];
		s.re = d[SYN_RE_BIT];
		s.master_slave_select = d[SYN_MSS_BIT];
		s.bidirectional_select = d[SYN_BIDIRECTIONAL_SELECT_BIT];
		s.serial_clock_select = d[SYN_SERIAL_CLOCK_SELECT_BIT];
		s.cs = d[SYN_CS_LSB +: 2];
		s.mode = d[SYN_MODE_BIT];
		return s;
	endfunction

	// Packs a sync unit configuration for readback.
	function automatic logic [DATA_W-1:0] from_sync(input poes_sync_type s);
		logic [DATA_W-1:0] d;
		d = '0;
		d[SYN_TE_BIT] = s.te;
		d[SYN_RE_BIT] = s.re;
		d[SYN_MSS_BIT] = s.master_slave_select;
		d[SYN_BIDIRECTIONAL_SELECT_BIT] = s.bidirectional_select;
		d[SYN_SERIAL_CLOCK_SELECT_BIT] = s.serial_clock_select;
		d[SYN_CS_LSB +: 2] = s.cs;
		d[SYN_MODE_BIT] = s.mode;
		return d;
	endfunction

	// Timer pin fields and buffer mode flags.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tmrCfg_reg <= TMR_RST;
		end else if (regWrite) begin
			case (regAddr)
				OFS_TMR0_HI: begin
					tmrCfg_reg.pin_a_io_field <= regWdata[TIO_LO_LSB +: TIO_W];
					tmrCfg_reg.pin_b_io_field <= regWdata[TIO_HI_LSB +: TIO_W];
				end
				OFS_TMR0_LO: begin
					tmrCfg_reg.pin_c_io_field <= regWdata[TIO_LO_LSB +: TIO_W];
					tmrCfg_reg.pin_d_io_field <= regWdata[TIO_HI_LSB +: TIO_W];
				end
				OFS_TMR_MODE: begin
					tmrCfg_reg.bufA <= regWdata[TMODE_BUFA_BIT];
					tmrCfg_reg.bufB <= regWdata[TMODE_BUFB_BIT];
				end
				OFS_TMR1: begin
					tmrCfg_reg.t1ioA <= regWdata[TIO_LO_LSB +: TIO_W];
				end
				default: begin
					tmrCfg_reg <= tmrCfg_reg;
				end
			endcase
		end
	end

	// Serial channel 4 and clock output control.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			serCfg_reg <= SER_RST;
			clkCfg_reg <= CLK_RST;
		end else if (regWrite) begin
			if (regAddr == OFS_SER4) begin
				serCfg_reg.cke <= regWdata[SER_CKE_LSB +: 2];
				serCfg_reg.te <= regWdata[SER_TE_BIT];
				serCfg_reg.re <= regWdata[SER_RE_BIT];
				serCfg_reg.syncMode <= regWdata[SER_SYNC_BIT];
				serCfg_reg.gm <= regWdata[SER_GM_BIT];
				serCfg_reg.smart_card_select <= regWdata[SER_SMART_CARD_SELECT_BIT];
			end
			if (regAddr == OFS_CLK) begin
				clkCfg_reg.stop <= regWdata[CLK_STOP_BIT];
				clkCfg_reg.posel <= regWdata[CLK_POSEL_BIT];
			end
		end
	end

	// Sync serial unit controls, one word per unit.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int u = 0; u < NUM_SYNC; u++) begin
				syncCfg_reg[u] <= SYNC_RST;
			end
		end else if (regWrite) begin
			for (int u = 0; u < NUM_SYNC; u++) begin
				if (regAddr == sync_ofs(u)) begin
					syncCfg_reg[u] <= to_sync(regWdata);
				end
			end
		end
	end

	// Port direction bits, all inputs after reset.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dir_reg <= '0;
		end else if (regWrite && regAddr == OFS_DIR) begin
			dir_reg <= regWdata[NPINS-1:0];
		end
	end

	// Peripheral output enables from the configuration bits.
	always_comb begin
		periphOe = '0;
		periphOe[PIN_T1A] = poes_tio_drives(tmrCfg_reg.t1ioA);
		periphOe[PIN_T0D] = !tmrCfg_reg.bufB && poes_tio_drives(tmrCfg_reg.pin_d_io_field);
		// Pin C is judged by its own field.
		periphOe[PIN_T0C] = !tmrCfg_reg.bufA && poes_tio_drives(tmrCfg_reg.pin_c_io_field);
		periphOe[PIN_T0B] = poes_tio_drives(tmrCfg_reg.pin_b_io_field);
		periphOe[PIN_T0A] = poes_tio_drives(tmrCfg_reg.pin_a_io_field);
		if (serCfg_reg.smart_card_select) begin
			periphOe[PIN_SERIAL4_CLOCK_PIN] = (serCfg_reg.te || serCfg_reg.re)
				&& (serCfg_reg.gm || serCfg_reg.cke == CKE_OUT);
		end else begin
			periphOe[PIN_SERIAL4_CLOCK_PIN] = (serCfg_reg.te || serCfg_reg.re)
				&& (serCfg_reg.syncMode ? !serCfg_reg.cke[1]
				: serCfg_reg.cke == CKE_OUT);
		end
		periphOe[PIN_BCLK] = dir_reg[PIN_BCLK] && !clkCfg_reg.stop
			&& !clkCfg_reg.posel;
		// Each unit reads only its own control word.
		for (int u = 0; u < NUM_SYNC; u++) begin
			if (syncCfg_reg[u].mode) begin
				periphOe[PIN_SYNC_BASE + PINS_PER_SYNC * u + SYNC_SO] =
					syncCfg_reg[u].te;
			end else if (syncCfg_reg[u].master_slave_select) begin
				periphOe[PIN_SYNC_BASE + PINS_PER_SYNC * u + SYNC_SO] =
					syncCfg_reg[u].te
					&& (!syncCfg_reg[u].bidirectional_select || !syncCfg_reg[u].re);
			end else begin
				periphOe[PIN_SYNC_BASE + PINS_PER_SYNC * u + SYNC_SO] =
					syncCfg_reg[u].bidirectional_select && !syncCfg_reg[u].re
					&& syncCfg_reg[u].te;
			end
			periphOe[PIN_SYNC_BASE + PINS_PER_SYNC * u + SYNC_SI] =
				!syncCfg_reg[u].mode && !syncCfg_reg[u].master_slave_select
				&& !syncCfg_reg[u].bidirectional_select && syncCfg_reg[u].te;
			periphOe[PIN_SYNC_BASE + PINS_PER_SYNC * u + SYNC_SCK] =
				syncCfg_reg[u].master_slave_select && syncCfg_reg[u].serial_clock_select;
			periphOe[PIN_SYNC_BASE + PINS_PER_SYNC * u + SYNC_CS] =
				(syncCfg_reg[u].cs == CS_ALWAYS)
				|| (syncCfg_reg[u].cs == CS_MASTER && !syncCfg_reg[u].mode
				&& syncCfg_reg[u].master_slave_select);
		end
	end

	// Pin drive: a peripheral owns its pin first, else the direction bit decides.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinPeriph <= '0;
			pinOe <= '0;
		end else begin
			pinPeriph <= periphOe;
			pinOe <= periphOe | dir_reg;
		end
	end

	// Readback value for the addressed register.
	always_comb begin
		rdata_next = '0;
		case (regAddr)
			OFS_TMR0_HI: begin
				rdata_next[TIO_LO_LSB +: TIO_W] = tmrCfg_reg.pin_a_io_field;
				rdata_next[TIO_HI_LSB +: TIO_W] = tmrCfg_reg.pin_b_io_field;
			end
			OFS_TMR0_LO: begin
				rdata_next[TIO_LO_LSB +: TIO_W] = tmrCfg_reg.pin_c_io_field;
				rdata_next[TIO_HI_LSB +: TIO_W] = tmrCfg_reg.pin_d_io_field;
			end
			OFS_TMR_MODE: begin
				rdata_next[TMODE_BUFA_BIT] = tmrCfg_reg.bufA;
				rdata_next[TMODE_BUFB_BIT] = tmrCfg_reg.bufB;
			end
			OFS_TMR1: begin
				rdata_next[TIO_LO_LSB +: TIO_W] = tmrCfg_reg.t1ioA;
			end
			OFS_SER4: begin
				rdata_next[SER_CKE_LSB +: 2] = serCfg_reg.cke;
				rdata_next[SER_TE_BIT] = serCfg_reg.te;
				rdata_next[SER_RE_BIT] = serCfg_reg.re;
				rdata_next[SER_SYNC_BIT] = serCfg_reg.syncMode;
				rdata_next[SER_GM_BIT] = serCfg_reg.gm;
				rdata_next[SER_SMART_CARD_SELECT_BIT] = serCfg_reg.smart_card_select;
			end
			OFS_CLK: begin
				rdata_next[CLK_STOP_BIT] = clkCfg_reg.stop;
				rdata_next[CLK_POSEL_BIT] = clkCfg_reg.posel;
			end
			OFS_DIR: begin
				rdata_next[NPINS-1:0] = dir_reg;
			end
			OFS_OE: begin
				rdata_next[NPINS-1:0] = pinOe;
			end
			OFS_PERIPH: begin
				rdata_next[NPINS-1:0] = pinPeriph;
			end
			default: begin
				for (int u = 0; u < NUM_SYNC; u++) begin
					if (regAddr == sync_ofs(u)) begin
						rdata_next = from_sync(syncCfg_reg[u]);
					end
				end
			end
		endcase
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regRdata <= '0;
		end else if (regRead) begin
			regRdata <= rdata_next;
		end else begin
			regRdata <= '0;
		end
	end

	// Timer, clock, direction and readback checks, one cycle after the configuration.
	AST_T1A_OFF: assert property (@(posedge clk) disable iff (!nrst)
		(tmrCfg_reg.t1ioA[3] || tmrCfg_reg.t1ioA[1:0] == TIO_OFF)
		|=> !pinPeriph[PIN_T1A])
		else $error("Timer1 pin A driven with an input field.");
	AST_T0D_BUF: assert property (@(posedge clk) disable iff (!nrst)
		(tmrCfg_reg.bufB || !poes_tio_drives(tmrCfg_reg.pin_d_io_field))
		##1 (tmrCfg_reg.bufB || !poes_tio_drives(tmrCfg_reg.pin_d_io_field))
		|-> !pinPeriph[PIN_T0D])
		else $error("Timer0 pin D driven in buffer mode or input field.");
	AST_T0C_ON: assert property (@(posedge clk) disable iff (!nrst)
		(!tmrCfg_reg.bufA && poes_tio_drives(tmrCfg_reg.pin_c_io_field))
		|=> pinPeriph[PIN_T0C] && pinOe[PIN_T0C])
		else $error("Timer0 pin C not driven.");
	AST_T0B_ON: assert property (@(posedge clk) disable iff (!nrst)
		poes_tio_drives(tmrCfg_reg.pin_b_io_field) |=> pinPeriph[PIN_T0B])
		else $error("Timer0 pin B not driven.");
	AST_T0A_OFF: assert property (@(posedge clk) disable iff (!nrst)
		tmrCfg_reg.pin_a_io_field[3] |=> !pinPeriph[PIN_T0A])
		else $error("Timer0 pin A driven with bit 3 set.");
	AST_SERIAL4_CLOCK_PIN_CARD: assert property (@(posedge clk) disable iff (!nrst)
		(serCfg_reg.smart_card_select && serCfg_reg.gm && (serCfg_reg.te || serCfg_reg.re))
		|=> pinPeriph[PIN_SERIAL4_CLOCK_PIN])
		else $error("Serial clock 4 not driven in special card mode.");
	AST_SERIAL4_CLOCK_PIN_ASYNC: assert property (@(posedge clk) disable iff (!nrst)
		(!serCfg_reg.smart_card_select && !serCfg_reg.syncMode && serCfg_reg.cke != CKE_OUT)
		|=> !pinPeriph[PIN_SERIAL4_CLOCK_PIN])
		else $error("Serial clock 4 driven with external clock.");
	AST_BCLK: assert property (@(posedge clk) disable iff (!nrst)
		pinPeriph[PIN_BCLK] |-> $past(dir_reg[PIN_BCLK]) && !$past(clkCfg_reg.stop)
		&& !$past(clkCfg_reg.posel))
		else $error("Bus clock driven while stopped, deselected or pin is input.");
	AST_DIR: assert property (@(posedge clk) disable iff (!nrst)
		(dir_reg == '0) |=> (pinOe == pinPeriph))
		else $error("Port output enabled with all direction bits clear.");
	AST_RDATA: assert property (@(posedge clk) disable iff (!nrst)
		(regRead && regAddr == OFS_DIR) |=> regRdata[NPINS-1:0] == $past(dir_reg))
		else $error("Direction readback wrong.");

	// Per-unit sync serial checks.
	for (genvar g = 0; g < NUM_SYNC; g++) begin : gSyncChk
		AST_SO_CLKSYNC: assert property (@(posedge clk) disable iff (!nrst)
			(syncCfg_reg[g].mode && syncCfg_reg[g].te)
			|=> pinPeriph[PIN_SYNC_BASE + PINS_PER_SYNC * g + SYNC_SO])
			else $error("Data out not driven in clock-synchronous mode.");
		AST_SO_SLAVE: assert property (@(posedge clk) disable iff (!nrst)
			(!syncCfg_reg[g].mode && !syncCfg_reg[g].master_slave_select && !syncCfg_reg[g].bidirectional_select)
			|=> !pinPeriph[PIN_SYNC_BASE + PINS_PER_SYNC * g + SYNC_SO])
			else $error("Slave data out driven without bidirectional mode.");
		AST_SO_MASTER: assert property (@(posedge clk) disable iff (!nrst)
			(!syncCfg_reg[g].mode && syncCfg_reg[g].master_slave_select && syncCfg_reg[g].te
			&& !syncCfg_reg[g].bidirectional_select)
			|=> pinPeriph[PIN_SYNC_BASE + PINS_PER_SYNC * g + SYNC_SO])
			else $error("Master data out not driven.");
		AST_SI: assert property (@(posedge clk) disable iff (!nrst)
			syncCfg_reg[g].master_slave_select |=> !pinPeriph[PIN_SYNC_BASE + PINS_PER_SYNC * g + SYNC_SI])
			else $error("Data in driven as master.");
		AST_SCK: assert property (@(posedge clk) disable iff (!nrst)
			!syncCfg_reg[g].serial_clock_select |=> !pinPeriph[PIN_SYNC_BASE + PINS_PER_SYNC * g + SYNC_SCK])
			else $error("Sync clock driven without clock select.");
		AST_CS: assert property (@(posedge clk) disable iff (!nrst)
			(syncCfg_reg[g].cs == CS_ALWAYS)
			|=> pinPeriph[PIN_SYNC_BASE + PINS_PER_SYNC * g + SYNC_CS])
			else $error("Chip select not driven on code 10.");
	end

	// Main scenarios.
	COV_TIMER_PIN: cover property (@(posedge clk) disable iff (!nrst)
		!pinPeriph[PIN_T0A] ##1 pinPeriph[PIN_T0A]);
	COV_PORT_OUT: cover property (@(posedge clk) disable iff (!nrst)
		pinOe[PIN_T1A] && !pinPeriph[PIN_T1A]);
	COV_BUS_CLOCK: cover property (@(posedge clk) disable iff (!nrst)
		pinPeriph[PIN_BCLK]);
	COV_SYNC_SLAVE_OUT: cover property (@(posedge clk) disable iff (!nrst)
		pinPeriph[PIN_SYNC_BASE + SYNC_SO] && $past(!syncCfg_reg[0].master_slave_select));

endmodule
`default_nettype wire

/* File: sim/poes_pin_model.sv */
// Pad model that resolves each shared pin from the selector's enables.
`default_nettype none
module poes_pin_model #(
	parameter int NPINS = 19
) (
	// Clock.
	input  wire logic             clk,
	// Enables from the selector.
	input  wire logic [NPINS-1:0] pinOe,
	input  wire logic [NPINS-1:0] pinPeriph,
	// Data offered by the peripherals and by the port.
	input  wire logic [NPINS-1:0] periphOut,
	input  wire logic [NPINS-1:0] portOut,
	// Resolved pad levels.
	output logic      [NPINS-1:0] pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NPINS-1:0] floatPat = '0;
	// A pad nobody drives has no keeper, so its level wanders every cycle.
	always @(posedge clk) begin
		floatPat <= ~floatPat;
	end
	// A driven pad carries peripheral data when owned by it, port data otherwise.
	assign pinLevel = (pinOe & ((pinPeriph & periphOut) | (~pinPeriph & portOut)))
		| (~pinOe & floatPat);
endmodule
`default_nettype wire

/* File: sim/poes_pin_mux_tb.sv */
// Self-checking testbench for the pin output-enable selector.
`default_nettype none
module poes_pin_mux_tb
	import poes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NP = PIN_SYNC_BASE + PINS_PER_SYNC * SYNC_UNITS;
	logic              clk      = 1'b0;
	logic              nrst     = 1'b0;
	logic [ADDR_W-1:0] regAddr  = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic              regWrite = 1'b0;
	logic              regRead  = 1'b0;
	logic [DATA_W-1:0] regRdata;
	logic [NP-1:0]     pinOe;
	logic [NP-1:0]     pinPeriph;
	logic [NP-1:0]     pinLevel;
	int                fails    = 0;
	int                n_tests  = 0;
	int                cycles   = 0;
	// Shadow copy of the configuration the bench has written.
	logic [7:0]        t0Hi, t0Lo, t1Cfg, serCfg;
	logic [7:0]        syncCfg [SYNC_UNITS];
	logic [1:0]        modeCfg, clkCfg;
	logic [NP-1:0]     dirCfg;

	// Clock of 40 ns period.
	always #20 clk = ~clk;

	// Device and the pads behind it.
	poes_pin_mux #(.NUM_SYNC(SYNC_UNITS)) u_poes_pin_mux (.clk(clk), .nrst(nrst),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .pinOe(pinOe), .pinPeriph(pinPeriph));
	poes_pin_model #(.NPINS(NP)) u_poes_pin_model (.clk(clk), .pinOe(pinOe),
		.pinPeriph(pinPeriph), .periphOut('1), .portOut('0), .pinLevel(pinLevel));

	// A timer pin field selects an output on bit 3 clear and a nonzero low pair.
	function automatic logic tio(input logic [3:0] f);
		return !f[3] && (f[1:0] != 2'h0);
	endfunction

	// Expected peripheral ownership worked out from the shadow configuration.
	function automatic logic [NP-1:0] exp_periph();
		logic [NP-1:0] e;
		logic [7:0]    s;
		int            b;
		e = '0;
		e[PIN_T1A] = tio(t1Cfg[3:0]);
		e[PIN_T0D] = !modeCfg[1] && tio(t0Lo[7:4]);
		e[PIN_T0C] = !modeCfg[0] && tio(t0Lo[3:0]);
		e[PIN_T0B] = tio(t0Hi[7:4]);
		e[PIN_T0A] = tio(t0Hi[3:0]);
		s = serCfg;
		if (s[6]) begin
			e[PIN_SERIAL4_CLOCK_PIN] = (s[2] || s[3]) && (s[5] || s[1:0] == 2'h1);
		end else begin
			e[PIN_SERIAL4_CLOCK_PIN] = (s[2] || s[3]) && (s[4] ? !s[1] : s[1:0] == 2'h1);
		end
		e[PIN_BCLK] = dirCfg[PIN_BCLK] && !clkCfg[0] && !clkCfg[1];
		for (int u = 0; u < SYNC_UNITS; u++) begin
			s = syncCfg[u];
			b = PIN_SYNC_BASE + PINS_PER_SYNC * u;
			e[b] = s[7] ? s[0]
				: (s[2] ? s[0] && (!s[3] || !s[1]) : s[3] && !s[1] && s[0]);
			e[b+1] = !s[7] && !s[2] && !s[3] && s[0];
			e[b+2] = s[2] && s[4];
			e[b+3] = (s[6:5] == 2'h2) || (s[6:5] == 2'h3 && !s[7] && s[2]);
		end
		return e;
	endfunction

	// Compare of register read data.
	task automatic chk_data(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compare of a pin vector.
	task automatic chk_pins(input string what, input logic [NP-1:0] exp, input logic [NP-1:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One-cycle register write.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	// One-cycle register read; data stand only in the following cycle.
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk_data(what, exp, regRdata);
		@(posedge clk);
		#1;
		chk_data({what, " cleared"}, '0, regRdata);
	endtask

	// Let the last write reach the pins, then check them all.
	task automatic settle_check();
		@(posedge clk);
		#1;
		chk_pins("pinPeriph", exp_periph(), pinPeriph);
		chk_pins("pinOe", exp_periph() | dirCfg, pinOe);
		chk_pins("pinLevel", exp_periph(), pinLevel & pinOe);
	endtask

	// Clear the shadow copy to the reset state.
	task automatic clear_shadow();
		{t0Hi, t0Lo, t1Cfg, serCfg, modeCfg, clkCfg, dirCfg} = '0;
		for (int u = 0; u < SYNC_UNITS; u++) syncCfg[u] = 8'h00;
	endtask

	// Print the counts and the verdict, then stop.
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Cut a hung run short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			give_verdict();
		end
	end

	// Main sequence.
	initial begin
		clear_shadow();
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk_pins("pinOe at reset", '0, pinOe);
		rd(OFS_DIR, '0, "direction at reset");
		for (int f = 0; f < 16; f++) begin
			t0Hi = {4'(f), 4'(~f)};
			t0Lo = {4'(f + 5), 4'(f)};
			t1Cfg = {4'h0, 4'(f + 9)};
			modeCfg = 2'(f / 4);
			wr(OFS_TMR0_HI, {24'h0, t0Hi});
			wr(OFS_TMR0_LO, {24'h0, t0Lo});
			wr(OFS_TMR1, {24'h0, t1Cfg});
			wr(OFS_TMR_MODE, {30'h0, modeCfg});
			settle_check();
		end
		rd(OFS_TMR_MODE, {30'h0, modeCfg}, "timer mode readback");
		t1Cfg = 8'h05;
		wr(OFS_TMR1, 32'hffffff05);
		rd(OFS_TMR1, 32'h00000005, "timer1 readback");
		rd(OFS_TMR0_LO, {24'h0, t0Lo}, "timer0 lo readback");
		for (int s = 0; s < 128; s++) begin
			serCfg = 8'(s);
			wr(OFS_SER4, {24'h0, serCfg});
			settle_check();
		end
		rd(OFS_SER4, {24'h0, serCfg & 8'h7f}, "serial readback");
		for (int c = 0; c < 8; c++) begin
			clkCfg = 2'(c);
			dirCfg = c[2] ? 19'h00040 : 19'h00000;
			wr(OFS_CLK, {30'h0, clkCfg});
			wr(OFS_DIR, 32'(dirCfg));
			settle_check();
		end
		rd(OFS_CLK, {30'h0, clkCfg}, "clock readback");
		for (int v = 0; v < 256; v++) begin
			syncCfg[0] = 8'(v);
			syncCfg[1] = 8'(v) ^ 8'h5a;
			syncCfg[2] = 8'(v) + 8'h3c;
			for (int u = 0; u < SYNC_UNITS; u++) begin
				wr(OFS_SYNC0 + 8'(4 * u), {24'h0, syncCfg[u]});
			end
			settle_check();
		end
		rd(OFS_SYNC0 + 8'h08, {24'h0, syncCfg[2]}, "sync unit 2 readback");
		dirCfg = 19'h5a5a5;
		wr(OFS_DIR, 32'(dirCfg));
		wr(OFS_OE, 32'hffffffff);
		wr(8'h40, 32'hffffffff);
		settle_check();
		rd(OFS_DIR, 32'(dirCfg), "direction readback");
		rd(OFS_OE, 32'(exp_periph() | dirCfg), "pinOe readback");
		rd(OFS_PERIPH, 32'(exp_periph()), "pinPeriph readback");
		rd(8'h40, '0, "unmapped read");
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		chk_pins("pinOe in reset", '0, pinOe);
		chk_pins("pinPeriph in reset", '0, pinPeriph);
		clear_shadow();
		@(posedge clk);
		nrst <= 1'b1;
		settle_check();
		give_verdict();
	end
endmodule
`default_nettype wire
